// ==== tb/cstc_ctrl_checker.sv ====
// Concurrent checks on the pins of the chip-select and transceiver control block.
`timescale 1ns/1ps
`default_nettype none
module cstc_ctrl_checker
  import cstc_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         sys_rst,
  input wire logic         avs_waitrequest,
  input wire cstc_access_t access,
  input wire logic         upperMemSelectNIn,
  input wire logic         lowerMemSelectNIn,
  input wire logic         midSelect0OrCoprocRequestIn,
  input wire logic         midSelect1OrCoprocErrorIn,
  input wire cstc_pins_t   pinOut,
  input wire cstc_pins_t   pinOe,
  input wire logic         coprocRequest,
  input wire logic         coprocError,
  input wire logic         holdGranted,
  input wire logic         onceMode
);
  logic memAcc;
  logic strapsLow;
  assign memAcc = access.active && access.mem;
  assign strapsLow = !upperMemSelectNIn && !lowerMemSelectNIn;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_inHold;
    holdGranted ##1 holdGranted;
  endsequence
  // Only the first reset edge drives the enable; a longer reset must leave it floating.
  sequence s_enPulse;
    pinOe.xcvrEnableN && pinOut.xcvrEnableN ##1 (!$past(sys_rst) || !pinOe.xcvrEnableN);
  endsequence
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles running");
  AST_UPPER: assert property (!pinOut.upperMemSelectN |-> $past(memAcc))
    else $error("upper select low without memory access");
  AST_LOWER: assert property (!pinOut.lowerMemSelectN |-> $past(memAcc))
    else $error("lower select low without memory access");
  AST_TURN: assert property ($changed(pinOut.xcvrDirection) && pinOe.xcvrDirection |->
      pinOut.xcvrEnableN)
    else $error("enable low while direction turned");
  AST_DIR: assert property (pinOe.xcvrEnableN && !pinOut.xcvrEnableN |->
      $past(access.active) && pinOut.xcvrDirection == $past(access.write))
    else $error("enable low with wrong direction or no access");
  AST_HOLD: assert property (s_inHold |->
      pinOut.upperMemSelectN && pinOut.lowerMemSelectN && &pinOut.periphSelectN
      && !pinOe.xcvrDirection && !pinOe.xcvrEnableN)
    else $error("bus not released during hold");
  AST_FLOAT: assert property (onceMode |=> pinOe == '0)
    else $error("pin driven in float test mode");
  AST_STRAP: assert property ($fell(sys_rst) |=> onceMode == $past(strapsLow))
    else $error("float test mode does not follow the straps");
  AST_EN_RESET: assert property (disable iff (1'b0) sys_rst && !$past(sys_rst) |=> s_enPulse)
    else $error("enable not high for exactly the first reset clock");
  AST_COPROC: assert property ((coprocRequest |-> !$past(midSelect0OrCoprocRequestIn))
      and (coprocError |-> !$past(midSelect1OrCoprocErrorIn)))
    else $error("coprocessor flag without its pin low");
endmodule
bind cstc_ctrl cstc_ctrl_checker u_cstc_ctrl_checker (
  .core_clk, .sys_rst, .avs_waitrequest, .access, .upperMemSelectNIn, .lowerMemSelectNIn,
  .midSelect0OrCoprocRequestIn, .midSelect1OrCoprocErrorIn, .pinOut, .pinOe, .coprocRequest,
  .coprocError, .holdGranted, .onceMode);
`default_nettype wire

// ==== tb/cstc_far_side.sv ====
// Far-side model: strap jumpers and the coprocessor lines that share the mid selects.
`timescale 1ns/1ps
`default_nettype none
module cstc_far_side
  import cstc_pkg::*;
(
  input  wire cstc_pins_t pinOut,
  input  wire cstc_pins_t pinOe,
  input  wire logic       strapLow,
  input  wire logic       reqOn,
  input  wire logic       errOn,
  output logic            upIn,
  output logic            loIn,
  output logic            m0In,
  output logic            m1In
);
  // A board pull-up holds each strap high unless the jumper logic pulls both low.
  assign upIn = pinOe.upperMemSelectN ? pinOut.upperMemSelectN : !strapLow;
  assign loIn = pinOe.lowerMemSelectN ? pinOut.lowerMemSelectN : !strapLow;
  assign m0In = pinOe.midSelect0OrCoprocRequest ?
                pinOut.midSelect0OrCoprocRequest : !reqOn;
  assign m1In = pinOe.midSelect1OrCoprocError ?
                pinOut.midSelect1OrCoprocError : !errOn;
endmodule
`default_nettype wire

// ==== tb/test_chip_select_transceiver_ctrl.sv ====
// Self-checking bench for the chip-select and transceiver control block.
`timescale 1ns/1ps
`default_nettype none
module test_chip_select_transceiver_ctrl
  import cstc_pkg::*;
  ;
  logic         core_clk;
  logic         sys_rst = 1'b1;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic         holdRequest = 1'b0;
  logic         strapLow = 1'b0;
  logic         reqOn = 1'b0;
  logic         errOn = 1'b0;
  logic [4:0]   avs_address = 5'h00;
  logic [31:0]  avs_writedata = 32'h0;
  cstc_access_t access = '0;
  logic [31:0]  avs_readdata, q;
  logic         avs_waitrequest, upIn, loIn, m0In, m1In, upPu, loPu, cpReq, cpErr;
  logic         holdGranted, onceMode;
  cstc_pins_t   pinOut, pinOe;
  logic [1:0]   dirEn;
  int           num_errors = 0;
  int           checks = 0;
  assign dirEn = {pinOut.xcvrDirection, pinOut.xcvrEnableN};
  cstc_ctrl u_cstc_ctrl (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .access, .holdRequest,
    .upperMemSelectNIn(upIn), .lowerMemSelectNIn(loIn), .midSelect0OrCoprocRequestIn(m0In),
    .midSelect1OrCoprocErrorIn(m1In), .pinOut, .pinOe, .upperPullupEn(upPu),
    .lowerPullupEn(loPu), .coprocRequest(cpReq), .coprocError(cpErr), .holdGranted, .onceMode);
  cstc_far_side u_cstc_far_side (.pinOut, .pinOe, .strapLow, .reqOn, .errOn, .upIn, .loIn,
    .m0In, .m1In);
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task close_out;
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task chb(input string nm, input logic seen, input logic exp);
    chk(nm, {31'h0, seen}, {31'h0, exp});
  endtask
  task av(input logic rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
    if (n == 20)
    begin
      num_errors++;
      close_out;
    end
  endtask
  // Pins are registered, so a check after n edges sees the decode of edge n-1.
  task go(input logic m, input logic w, input logic c, input logic [19:0] a, input int n);
    access <= '{1'b1, m, w, c, a};
    repeat (n) @(posedge core_clk);
  endtask
  task do_reset(input logic straps);
    strapLow <= straps;
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("pullups on", {30'h0, upPu, loPu}, 32'h3);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chb("float mode", onceMode, straps);
    chk("pullups off", {30'h0, upPu, loPu}, 32'h0);
    strapLow <= 1'b0;
  endtask
  task s_regs;
    av(1'b1, OFS_PERIPH_BASE, 32'h0, q);
    chk("periph reset", q, 32'h00100000);
    av(1'b1, 5'h1C, 32'h0, q);
    chk("unmapped", q, 32'h0);
    av(1'b0, OFS_LOWER_MASK, 32'h000FFFFF, q);
    av(1'b1, OFS_LOWER_MASK, 32'h0, q);
    chk("lower clamp", q, 32'h0003FFFF);
  endtask
  task s_mem;
    go(1'b1, 1'b0, 1'b0, 20'hFFC00, 2);
    chb("upper hit", pinOut.upperMemSelectN, 1'b0);
    go(1'b1, 1'b0, 1'b0, 20'hFFBFF, 2);
    chb("upper miss", pinOut.upperMemSelectN, 1'b1);
    go(1'b1, 1'b0, 1'b0, 20'h3FFFF, 2);
    chb("lower hit", pinOut.lowerMemSelectN, 1'b0);
    go(1'b1, 1'b0, 1'b0, 20'h40000, 2);
    chb("lower miss", pinOut.lowerMemSelectN, 1'b1);
    go(1'b1, 1'b0, 1'b0, 20'h81000, 2);
    chb("mid hit", pinOut.midSelect2N, 1'b0);
    go(1'b1, 1'b0, 1'b0, 20'h80000, 2);
    chb("mid0 hit", pinOut.midSelect0OrCoprocRequest, 1'b0);
    go(1'b1, 1'b0, 1'b0, 20'h81800, 2);
    chb("mid3 hit", pinOut.midSelect3OrCoprocSelect, 1'b0);
  endtask
  task s_periph;
    for (int j = 0; j < 5; j++)
    begin
      go(1'b0, 1'b0, 1'b0, 20'(128 * j), 2);
      chk("periph", {27'h0, pinOut.periphSelectN}, {27'h0, ~(5'h01 << j)});
    end
    go(1'b0, 1'b0, 1'b0, 20'h00280, 2);
    chb("periph5", pinOut.periphSelect5OrLatchedAddr1, 1'b0);
    av(1'b0, OFS_PERIPH_BASE, 32'h000C0000, q);
    go(1'b1, 1'b0, 1'b0, 20'hC0300, 2);
    chb("periph6 mem", pinOut.periphSelect6OrLatchedAddr2, 1'b0);
  endtask
  task s_xcvr;
    go(1'b0, 1'b1, 1'b0, 20'h00010, 3);
    chk("write", 32'(dirEn), 32'h2);
    go(1'b0, 1'b0, 1'b0, 20'h00010, 2);
    chk("turn", 32'(dirEn), 32'h1);
    @(posedge core_clk);
    chk("read", 32'(dirEn), 32'h0);
    access.active <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("idle", 32'(dirEn), 32'h1);
  endtask
  task s_enh;
    av(1'b0, OFS_CTRL, 32'h1, q);
    reqOn <= 1'b1;
    errOn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("coproc in", {30'h0, cpReq, cpErr}, 32'h3);
    av(1'b1, OFS_STATUS, 32'h0, q);
    chk("status", q & 32'hC, 32'hC);
    reqOn <= 1'b0;
    errOn <= 1'b0;
    go(1'b0, 1'b1, 1'b1, 20'h000F8, 2);
    chb("coproc sel", pinOut.midSelect3OrCoprocSelect, 1'b0);
    go(1'b1, 1'b0, 1'b0, 20'h81800, 2);
    chb("mid3 off", pinOut.midSelect3OrCoprocSelect, 1'b1);
  endtask
  task s_hold;
    av(1'b0, OFS_CTRL, 32'h2, q);
    // Address bit 1 set and bit 2 clear, so a latch stuck at the idle level shows up.
    go(1'b0, 1'b0, 1'b0, 20'h00002, 2);
    access.active <= 1'b0;
    holdRequest <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("hold out", {27'h0, holdGranted, pinOut.holdGrant, pinOut.upperMemSelectN,
      pinOut.periphSelect5OrLatchedAddr1, pinOut.periphSelect6OrLatchedAddr2}, 32'h1E);
    chk("hold oe", {28'h0, pinOe.periphSelect5OrLatchedAddr1,
      pinOe.periphSelect6OrLatchedAddr2, pinOe.xcvrDirection, pinOe.xcvrEnableN}, 32'hC);
    holdRequest <= 1'b0;
    repeat (2) @(posedge core_clk);
    chb("hold off", holdGranted, 1'b0);
  endtask
  task s_on_circuit_float_test;
    do_reset(1'b1);
    @(posedge core_clk);
    chk("float", 32'(pinOe), 32'h0);
    do_reset(1'b0);
  endtask
  initial
  begin
    do_reset(1'b0);
    s_regs;
    s_mem;
    s_periph;
    s_xcvr;
    s_enh;
    s_hold;
    s_on_circuit_float_test;
    close_out;
  end
endmodule
`default_nettype wire

// ==== verilog/cstc_ctrl.sv ====
// Chip-select, coprocessor handshake and data transceiver control with Avalon-MM configuration.
// Operation
// - Upper select low on upper block hit.
// - Lower select low on lower block hit.
// - Both straps low at release enters float test.
// - Float test floats every pin until reset.
// - Weak pull-ups on straps only during reset.
// - Mid selects low on mid-range region hit.
// - Enhanced mode: mid0 is coprocessor request input.
// - Enhanced mode: mid3 selects coprocessor only.
// - Enhanced mode: mid1 is coprocessor error input.
// - Peripheral selects 0-4 low on area hit.
// - Pin five: select or latched A1, driven.
// - Pin six: select or latched A2, driven.
// - Direction high writing, low reading.
// - Enable low per access, high on turn.
// - Enable high one clock in reset, floats.
// - Hold grant drives selects high, floats transceiver lines.
`timescale 1ns/1ps
`default_nettype none
module cstc_ctrl
  import cstc_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic [AVS_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire cstc_access_t          access,
  input  wire logic                  holdRequest,
  input  wire logic                  upperMemSelectNIn,
  input  wire logic                  lowerMemSelectNIn,
  input  wire logic                  midSelect0OrCoprocRequestIn,
  input  wire logic                  midSelect1OrCoprocErrorIn,
  output cstc_pins_t                 pinOut,
  output cstc_pins_t                 pinOe,
  output logic                       upperPullupEn,
  output logic                       lowerPullupEn,
  output logic                       coprocRequest,
  output logic                       coprocError,
  output logic                       holdGranted,
  output logic                       onceMode
);

  logic [19:0] upperMask_reg;
  logic [19:0] lowerMask_reg;
  logic [19:0] midBase_reg;
  logic [19:0] midMask_reg;
  logic [19:0] periphBase_reg;
  logic        periphIo_reg;
  logic        enhanced_reg;
  logic        latchedMode_reg;
  logic        waitReq_reg;
  logic [31:0] readData_reg;
  logic [31:0] readData_next;
  logic        inReset_reg;
  logic        holdGrant_reg;
  logic        latchA1_reg;
  logic        latchA2_reg;
  logic        pullup_reg;
  logic        coprocRequest_reg;
  logic        coprocError_reg;
  cstc_pins_t  pinOut_reg;
  cstc_pins_t  pinOut_next;
  cstc_pins_t  pinOe_reg;
  cstc_pins_t  pinOe_next;
  logic        upperHit;
  logic        lowerHit;
  logic [3:0]  midHit;
  logic [6:0]  periphHit;
  logic        busTake;
  logic        busCommit;
  logic        memCycle;
  logic        periphCycle;

  assign busTake   = (avs_read | avs_write) & waitReq_reg;
  assign busCommit = avs_write & ~waitReq_reg;

  // Avalon-MM handshake: waitrequest drops for exactly one cycle per request.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      waitReq_reg <= 1'b1;
    else
      waitReq_reg <= ~busTake;
  end

  always_comb
  begin
    readData_next = 32'h00000000;
    unique case (avs_address)
      OFS_UPPER_MASK:  readData_next[19:0] = upperMask_reg;
      OFS_LOWER_MASK:  readData_next[19:0] = lowerMask_reg;
      OFS_MID_BASE:    readData_next[19:0] = midBase_reg;
      OFS_MID_MASK:    readData_next[19:0] = midMask_reg;
      OFS_PERIPH_BASE:
      begin
        readData_next[19:0]          = periphBase_reg;
        readData_next[PERIPH_IO_BIT] = periphIo_reg;
      end
      OFS_CTRL:
      begin
        readData_next[CTRL_ENHANCED_BIT] = enhanced_reg;
        readData_next[CTRL_LATCHED_BIT]  = latchedMode_reg;
      end
      OFS_STATUS:
      begin
        readData_next[STAT_ON_CIRCUIT_FLOAT_TEST_BIT] = onceMode;
        readData_next[STAT_HOLD_BIT] = holdGrant_reg;
        readData_next[STAT_REQ_BIT]  = coprocRequest_reg;
        readData_next[STAT_ERR_BIT]  = coprocError_reg;
      end
      default:         readData_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      readData_reg <= 32'h00000000;
    else if (busTake & avs_read)
      readData_reg <= readData_next;
  end

  // Sizes written are forced into range: the minimum mask bits are set and bits above the maximum mask are cleared.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      upperMask_reg   <= RST_UPPER_MASK;
      lowerMask_reg   <= RST_LOWER_MASK;
      midBase_reg     <= RST_MID_BASE;
      midMask_reg     <= RST_MID_MASK;
      periphBase_reg  <= RST_PERIPH_BASE;
      periphIo_reg    <= RST_PERIPH_IO;
      enhanced_reg    <= 1'b0;
      latchedMode_reg <= 1'b0;
    end
    else if (busCommit)
    begin
      unique case (avs_address)
        OFS_UPPER_MASK:  upperMask_reg <= (avs_writedata[19:0] | BLOCK_MASK_MIN) & BLOCK_MASK_MAX;
        OFS_LOWER_MASK:  lowerMask_reg <= (avs_writedata[19:0] | BLOCK_MASK_MIN) & BLOCK_MASK_MAX;
        OFS_MID_BASE:    midBase_reg   <= avs_writedata[19:0];
        OFS_MID_MASK:    midMask_reg   <= (avs_writedata[19:0] | MID_BLK_MASK_MIN) & MID_BLK_MASK_MAX;
        OFS_PERIPH_BASE:
        begin
          periphBase_reg <= avs_writedata[19:0];
          periphIo_reg   <= avs_writedata[PERIPH_IO_BIT];
        end
        OFS_CTRL:
        begin
          enhanced_reg    <= avs_writedata[CTRL_ENHANCED_BIT];
          latchedMode_reg <= avs_writedata[CTRL_LATCHED_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  cstc_range_dec u_upper_dec (
    .addr (access.addr),
    .base (UPPER_BASE),
    .mask (upperMask_reg),
    .hit  (upperHit)
  );

  cstc_range_dec u_lower_dec (
    .addr (access.addr),
    .base (LOWER_BASE),
    .mask (lowerMask_reg),
    .hit  (lowerHit)
  );

  // Four equal mid-range blocks laid end to end from the programmed base.
  for (genvar i = 0; i < 4; i++)
  begin : g_mid
    cstc_range_dec u_mid_dec (
      .addr (access.addr),
      .base (20'(midBase_reg + 20'((midMask_reg + 20'h00001) * i))),
      .mask (midMask_reg),
      .hit  (midHit[i])
    );
  end

  // Seven consecutive peripheral blocks from the programmed base.
  for (genvar j = 0; j < 7; j++)
  begin : g_periph
    cstc_range_dec u_periph_dec (
      .addr (access.addr),
      .base (20'(periphBase_reg + 20'((PERIPH_BLK_MASK + 20'h00001) * j))),
      .mask (PERIPH_BLK_MASK),
      .hit  (periphHit[j])
    );
  end

  cstc_on_circuit_float_test_capture u_on_circuit_float_test (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .upperIn  (upperMemSelectNIn),
    .lowerIn  (lowerMemSelectNIn),
    .onceMode (onceMode)
  );

  assign memCycle    = access.active & access.mem & ~access.coproc;
  assign periphCycle = access.active & ~access.coproc & (access.mem != periphIo_reg);

  always_ff @(posedge core_clk)
  begin
    inReset_reg <= sys_rst;
  end

  // Grant is only given between cycles so that a running access is never cut.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      holdGrant_reg <= 1'b0;
    else if (!holdRequest)
      holdGrant_reg <= 1'b0;
    else if (!access.active)
      holdGrant_reg <= 1'b1;
  end

  // Address bits are latched per cycle and kept frozen while the bus is granted away.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      latchA1_reg <= 1'b0;
      latchA2_reg <= 1'b0;
    end
    else if (access.active && !holdGrant_reg)
    begin
      latchA1_reg <= access.addr[1];
      latchA2_reg <= access.addr[2];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      pullup_reg <= 1'b1;
    else
      pullup_reg <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      coprocRequest_reg <= 1'b0;
      coprocError_reg   <= 1'b0;
    end
    else
    begin
      coprocRequest_reg <= enhanced_reg & ~midSelect0OrCoprocRequestIn;
      coprocError_reg   <= enhanced_reg & ~midSelect1OrCoprocErrorIn;
    end
  end

  always_comb
  begin
    pinOut_next = '1;
    pinOe_next  = '1;
    pinOut_next.holdGrant = holdGrant_reg;
    pinOut_next.upperMemSelectN = ~(memCycle & upperHit);
    pinOut_next.lowerMemSelectN = ~(memCycle & lowerHit);
    pinOut_next.midSelect0OrCoprocRequest = ~(memCycle & midHit[0]);
    pinOut_next.midSelect1OrCoprocError   = ~(memCycle & midHit[1]);
    pinOut_next.midSelect2N               = ~(memCycle & midHit[2]);
    pinOut_next.periphSelectN = ~({5{periphCycle}} & periphHit[4:0]);
    if (enhanced_reg)
    begin
      pinOe_next.midSelect0OrCoprocRequest = 1'b0;
      pinOe_next.midSelect1OrCoprocError   = 1'b0;
      pinOut_next.midSelect3OrCoprocSelect = ~(access.active & access.coproc);
    end
    else
      pinOut_next.midSelect3OrCoprocSelect = ~(memCycle & midHit[3]);
    if (latchedMode_reg)
    begin
      pinOut_next.periphSelect5OrLatchedAddr1 = access.active ? access.addr[1] : latchA1_reg;
      pinOut_next.periphSelect6OrLatchedAddr2 = access.active ? access.addr[2] : latchA2_reg;
    end
    else
    begin
      pinOut_next.periphSelect5OrLatchedAddr1 = ~(periphCycle & periphHit[5]);
      pinOut_next.periphSelect6OrLatchedAddr2 = ~(periphCycle & periphHit[6]);
    end
    // Direction may only move while the enable sits high, so a turn costs one cycle.
    pinOut_next.xcvrDirection = access.active ? access.write : pinOut_reg.xcvrDirection;
    pinOut_next.xcvrEnableN = ~(access.active & (pinOut_reg.xcvrDirection == access.write)
                                & pinOe_reg.xcvrDirection);
    if (sys_rst)
    begin
      pinOut_next = '1;
      pinOut_next.holdGrant = 1'b0;
      pinOe_next.upperMemSelectN = 1'b0;
      pinOe_next.lowerMemSelectN = 1'b0;
      pinOe_next.midSelect0OrCoprocRequest = 1'b0;
      pinOe_next.midSelect1OrCoprocError   = 1'b0;
      pinOe_next.xcvrDirection = 1'b0;
      pinOe_next.xcvrEnableN = ~inReset_reg;
    end
    else if (onceMode)
      pinOe_next = '0;
    else if (holdGrant_reg)
    begin
      pinOut_next.upperMemSelectN = 1'b1;
      pinOut_next.lowerMemSelectN = 1'b1;
      pinOut_next.midSelect0OrCoprocRequest = 1'b1;
      pinOut_next.midSelect1OrCoprocError   = 1'b1;
      pinOut_next.midSelect2N              = 1'b1;
      pinOut_next.midSelect3OrCoprocSelect = 1'b1;
      pinOut_next.periphSelectN = 5'h1F;
      if (latchedMode_reg)
      begin
        pinOut_next.periphSelect5OrLatchedAddr1 = latchA1_reg;
        pinOut_next.periphSelect6OrLatchedAddr2 = latchA2_reg;
      end
      else
      begin
        pinOut_next.periphSelect5OrLatchedAddr1 = 1'b1;
        pinOut_next.periphSelect6OrLatchedAddr2 = 1'b1;
      end
      pinOut_next.xcvrEnableN = 1'b1;
      pinOe_next.xcvrDirection = 1'b0;
      pinOe_next.xcvrEnableN   = 1'b0;
    end
    else if (!pinOe_reg.xcvrDirection && !access.active)
      pinOe_next.xcvrDirection = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    pinOut_reg <= pinOut_next;
    pinOe_reg  <= pinOe_next;
  end

  assign pinOut          = pinOut_reg;
  assign pinOe           = pinOe_reg;
  assign upperPullupEn   = pullup_reg;
  assign lowerPullupEn   = pullup_reg;
  assign coprocRequest   = coprocRequest_reg;
  assign coprocError     = coprocError_reg;
  assign holdGranted     = holdGrant_reg;
  assign avs_readdata    = readData_reg;
  assign avs_waitrequest = waitReq_reg;

endmodule
`default_nettype wire

// ==== verilog/cstc_on_circuit_float_test_capture.sv ====
// Samples the two strap pins when reset is released and holds the float-test mode flag.
`timescale 1ns/1ps
`default_nettype none
module cstc_on_circuit_float_test_capture
  import cstc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic upperIn,
  input  wire logic lowerIn,
  output logic      onceMode
);

  logic inReset_reg;
  logic onceMode_reg;

  always_ff @(posedge core_clk)
  begin
    inReset_reg <= sys_rst;
  end

  // The straps are caught on the first clock after release, never under reset itself.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      onceMode_reg <= 1'b0;
    else if (inReset_reg)
      onceMode_reg <= ~upperIn & ~lowerIn;
  end

  assign onceMode = onceMode_reg;

endmodule
`default_nettype wire

// ==== verilog/cstc_pkg.sv ====
// Package with constants and carrier types of the chip-select and transceiver control block.
package cstc_pkg;

  localparam int unsigned ADDR_W = 20;
  localparam int unsigned AVS_ADDR_W = 5;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] OFS_UPPER_MASK  = 5'h00;
  localparam logic [4:0] OFS_LOWER_MASK  = 5'h04;
  localparam logic [4:0] OFS_MID_BASE    = 5'h08;
  localparam logic [4:0] OFS_MID_MASK    = 5'h0C;
  localparam logic [4:0] OFS_PERIPH_BASE = 5'h10;
  localparam logic [4:0] OFS_CTRL        = 5'h14;
  localparam logic [4:0] OFS_STATUS      = 5'h18;

  // Field positions.
  localparam int unsigned CTRL_ENHANCED_BIT = 0;
  localparam int unsigned CTRL_LATCHED_BIT  = 1;
  localparam int unsigned PERIPH_IO_BIT     = 20;
  localparam int unsigned STAT_ON_CIRCUIT_FLOAT_TEST_BIT     = 0;
  localparam int unsigned STAT_HOLD_BIT     = 1;
  localparam int unsigned STAT_REQ_BIT      = 2;
  localparam int unsigned STAT_ERR_BIT      = 3;

  // Size limits as masks of the address bits inside one block, and the fixed upper and lower block bases.
  localparam logic [19:0] BLOCK_MASK_MIN     = 20'h003FF;
  localparam logic [19:0] BLOCK_MASK_MAX     = 20'h3FFFF;
  localparam logic [19:0] MID_BLK_MASK_MIN   = 20'h007FF;
  localparam logic [19:0] MID_BLK_MASK_MAX   = 20'h1FFFF;
  localparam logic [19:0] PERIPH_BLK_MASK    = 20'h0007F;
  localparam logic [19:0] UPPER_BASE         = 20'hFFFFF;
  localparam logic [19:0] LOWER_BASE         = 20'h00000;

  // Reset values.
  localparam logic [19:0] RST_UPPER_MASK  = 20'h003FF;
  localparam logic [19:0] RST_LOWER_MASK  = 20'h003FF;
  localparam logic [19:0] RST_MID_BASE    = 20'h80000;
  localparam logic [19:0] RST_MID_MASK    = 20'h007FF;
  localparam logic [19:0] RST_PERIPH_BASE = 20'h00000;
  localparam logic        RST_PERIPH_IO   = 1'b1;

  // One bus cycle as presented by the core.
  typedef struct packed {
    logic        active;
    logic        mem;
    logic        write;
    logic        coproc;
    logic [19:0] addr;
  } cstc_access_t;

  // Pin group; used both for the driven level and for the output enable.
  typedef struct packed {
    logic       upperMemSelectN;
    logic       lowerMemSelectN;
    logic       midSelect0OrCoprocRequest;
    logic       midSelect1OrCoprocError;
    logic       midSelect2N;
    logic       midSelect3OrCoprocSelect;
    logic [4:0] periphSelectN;
    logic       periphSelect5OrLatchedAddr1;
    logic       periphSelect6OrLatchedAddr2;
    logic       xcvrDirection;
    logic       xcvrEnableN;
    logic       holdGrant;
  } cstc_pins_t;

endpackage

// ==== verilog/cstc_range_dec.sv ====
// Address window decoder: hit when the address matches the base outside the block mask.
`timescale 1ns/1ps
`default_nettype none
module cstc_range_dec
  import cstc_pkg::*;
#(
  parameter int unsigned W = ADDR_W
)(
  input  wire logic [W-1:0] addr,
  input  wire logic [W-1:0] base,
  input  wire logic [W-1:0] mask,
  output logic              hit
);

  assign hit = (((addr ^ base) & ~mask) == '0);

endmodule
`default_nettype wire
